/* File: oled_cmd_pkg.sv */
// Constants shared by the OLED command decoder: register offsets, field
// positions, command codes and reset values. Assumes an AXI4-Lite master.
package oled_cmd_pkg;
   // Register byte offsets.
   localparam logic [4:0] OFF_CMD = 5'h00;
   localparam logic [4:0] OFF_CONFIG = 5'h04;
   localparam logic [4:0] OFF_COLUMN = 5'h08;
   localparam logic [4:0] OFF_DATA = 5'h0C;
   // Command word fields.
   localparam int CMD_SEL_BIT = 8;
   // Configuration word fields.
   localparam int CFG_CONTRAST_LSB = 0;
   localparam int CFG_MUX_LSB = 8;
   localparam int CFG_PAGE_LSB = 16;
   localparam int CFG_REMAP_BIT = 20;
   localparam int CFG_ENTIRE_BIT = 21;
   localparam int CFG_DISP_BIT = 22;
   localparam int CFG_BOOST_BIT = 23;
   localparam int CFG_SCAN_BIT = 24;
   localparam int CFG_INVERT_BIT = 25;
   localparam int CFG_STATE_LSB = 26;
   // Command codes.
   localparam logic [7:0] OP_CONTRAST = 8'h81;
   localparam logic [7:0] OP_REMAP = 8'hA0;
   localparam logic [7:0] OP_ENTIRE = 8'hA4;
   localparam logic [7:0] OP_INVERT = 8'hA6;
   localparam logic [7:0] OP_MUX = 8'hA8;
   localparam logic [7:0] OP_BOOST = 8'hAD;
   localparam logic [7:0] OP_DISPLAY = 8'hAE;
   localparam logic [4:0] OP_PAGE_HI = 5'h16;
   localparam logic [3:0] OP_SCAN_HI = 4'hC;
   localparam logic [7:0] OP_OFFSET = 8'hD3;
   localparam logic [7:0] OP_CLKDIV = 8'hD5;
   localparam logic [7:0] OP_PRECHG = 8'hD9;
   localparam logic [7:0] OP_COMPADS = 8'hDA;
   localparam logic [7:0] OP_VCOMH = 8'hDB;
   // Reset values and limits.
   localparam logic [7:0] RST_CONTRAST = 8'h80;
   localparam logic [5:0] RST_MUX = 6'h3F;
   localparam logic [7:0] COL_MAX = 8'h84;
   // Responses.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Decoder states.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CONTRAST = 3'b001,
      ST_MUX = 3'b010,
      ST_BOOST = 3'b011,
      ST_SKIP = 3'b100
   } dec_state_e;
endpackage

/* File: oled_display_command_decoder.sv */
// Command decoder of a dot-matrix OLED driver, reached over AXI4-Lite.
// Assumes one clock, an AXI4-Lite master that offers address and data
// together, and display RAM and analog drivers living outside this block.
// Function
// - Contrast mode byte makes next byte contrast.
// - Contrast mode accepts only the contrast byte.
// - Contrast byte stored ends contrast mode.
// - Contrast register resets to 80 hex.
// - Remap bit zero: normal, one: reversed.
// - Each RAM access advances column by one.
// - Entire-on forces pixels, RAM kept intact.
// - Entire-on overrides normal or inverse setting.
// - Mux byte low six bits, rows plus one.
// - Converter byte lowest bit enables converter.
// - Off means sleep; on selects supply source.
// - Display command bit zero: off or on.
// - Display off stops oscillator, converter, drivers.
// - Sleep keeps settings and allows RAM access.
// - Page command loads page zero to seven.
// - Page change leaves panel image unchanged.
// - Scan bit three selects scan direction.
// - Scan direction takes effect from next row.
// - Column stops at 132, page stays.
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ns
module oled_display_command_decoder (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // AXI4-Lite write address and data.
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response.
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read.
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pixel path from display RAM to the segment drivers.
   input wire logic ramPixel,
   output logic pixelOut,
   // Panel control outputs.
   output logic [7:0] contrast,
   output logic segRemap,
   output logic [6:0] activeRows,
   output logic scanReverse,
   output logic [2:0] pageAddr,
   output logic [7:0] columnAddr,
   output logic sleepMode,
   output logic oscEnable,
   output logic boostConverterOn,
   output logic externalSupply,
   output logic driverOe
);
   logic awReady_r, wReady_r, bValid_r, arReady_r, rValid_r;
   logic [1:0] bResp_r, rResp_r;
   logic [31:0] rData_r;
   logic [4:0] awAddr_r, arAddr_r;
   logic [31:0] wData_r;
   logic [3:0] wStrb_r;
   logic wrFire, rdFire;
   logic byteWr, dataWr, dataRd, cmdWr;
   logic [7:0] cmdByte;
   oled_cmd_pkg::dec_state_e state_r, state_nxt;
   logic [7:0] contrast_r;
   logic [5:0] muxCode_r;
   logic [2:0] page_r;
   logic [7:0] column_r, column_nxt;
   logic remap_r, entireOn_r, invert_r, dispOn_r, boostEn_r, scanRev_r;
   logic pixel_r, sleep_r, osc_r, boostOn_r, extSup_r, drvOe_r;
   logic wrMapped, rdMapped;
   logic [31:0] cfgWord;
   logic [1:0] incCount;
   logic [8:0] colSum;
   logic [6:0] activeRows_r;
   logic idleCmd;

   // Write handshake: both channels are accepted together, one cycle after
   // both are offered, then the response is held until bready.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         awReady_r <= 1'b0;
         wReady_r <= 1'b0;
         bValid_r <= 1'b0;
         bResp_r <= oled_cmd_pkg::RESP_OKAY;
         awAddr_r <= 5'h00;
         wData_r <= 32'h00000000;
         wStrb_r <= 4'h0;
      end else begin
         if (wrFire) begin
            awReady_r <= 1'b0;
            wReady_r <= 1'b0;
            bValid_r <= 1'b1;
            bResp_r <= wrMapped ? oled_cmd_pkg::RESP_OKAY : oled_cmd_pkg::RESP_SLVERR;
         end else if (s_axi_awvalid && s_axi_wvalid && !awReady_r && !bValid_r) begin
            awReady_r <= 1'b1;
            wReady_r <= 1'b1;
         end
         if (bValid_r && s_axi_bready) begin
            bValid_r <= 1'b0;
         end
         if (s_axi_awvalid && s_axi_wvalid && !awReady_r) begin
            awAddr_r <= s_axi_awaddr;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
      end
   end

   // The write takes effect on the cycle both ready flags meet valid.
   assign wrFire = awReady_r && s_axi_awvalid && wReady_r && s_axi_wvalid;
   assign wrMapped = (awAddr_r == oled_cmd_pkg::OFF_CMD) ||
      (awAddr_r == oled_cmd_pkg::OFF_COLUMN);
   assign byteWr = wrFire && wStrb_r[0] && (awAddr_r == oled_cmd_pkg::OFF_CMD);
   assign dataWr = byteWr && wData_r[oled_cmd_pkg::CMD_SEL_BIT];
   assign cmdWr = byteWr && !wData_r[oled_cmd_pkg::CMD_SEL_BIT];
   assign cmdByte = wData_r[7:0];

   // Read handshake: address taken one cycle after arvalid, data next cycle.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         arReady_r <= 1'b0;
         rValid_r <= 1'b0;
         rData_r <= 32'h00000000;
         rResp_r <= oled_cmd_pkg::RESP_OKAY;
         arAddr_r <= 5'h00;
      end else begin
         if (rdFire) begin
            arReady_r <= 1'b0;
            rValid_r <= 1'b1;
            rResp_r <= rdMapped ? oled_cmd_pkg::RESP_OKAY : oled_cmd_pkg::RESP_SLVERR;
            case (arAddr_r)
               oled_cmd_pkg::OFF_CONFIG: rData_r <= cfgWord;
               oled_cmd_pkg::OFF_COLUMN: rData_r <= {24'h000000, column_r};
               default: rData_r <= 32'h00000000;
            endcase
         end else if (s_axi_arvalid && !arReady_r && !rValid_r) begin
            arReady_r <= 1'b1;
            arAddr_r <= s_axi_araddr;
         end
         if (rValid_r && s_axi_rready) begin
            rValid_r <= 1'b0;
         end
      end
   end

   assign rdFire = arReady_r && s_axi_arvalid;
   assign rdMapped = (arAddr_r == oled_cmd_pkg::OFF_CMD) ||
      (arAddr_r == oled_cmd_pkg::OFF_CONFIG) ||
      (arAddr_r == oled_cmd_pkg::OFF_COLUMN) ||
      (arAddr_r == oled_cmd_pkg::OFF_DATA);
   // Reading the data window stands for a display RAM read; RAM lives outside.
   assign dataRd = rdFire && (arAddr_r == oled_cmd_pkg::OFF_DATA);

   // Status word built from the live settings.
   always_comb begin
      cfgWord = 32'h00000000;
      cfgWord[oled_cmd_pkg::CFG_CONTRAST_LSB +: 8] = contrast_r;
      cfgWord[oled_cmd_pkg::CFG_MUX_LSB +: 6] = muxCode_r;
      cfgWord[oled_cmd_pkg::CFG_PAGE_LSB +: 3] = page_r;
      cfgWord[oled_cmd_pkg::CFG_REMAP_BIT] = remap_r;
      cfgWord[oled_cmd_pkg::CFG_ENTIRE_BIT] = entireOn_r;
      cfgWord[oled_cmd_pkg::CFG_DISP_BIT] = dispOn_r;
      cfgWord[oled_cmd_pkg::CFG_BOOST_BIT] = boostEn_r;
      cfgWord[oled_cmd_pkg::CFG_SCAN_BIT] = scanRev_r;
      cfgWord[oled_cmd_pkg::CFG_INVERT_BIT] = invert_r;
      cfgWord[oled_cmd_pkg::CFG_STATE_LSB +: 3] = state_r;
   end

   // Decoder sequencing: a mode byte arms a state that claims the next byte.
   always_comb begin
      state_nxt = state_r;
      if (cmdWr) begin
         case (state_r)
            oled_cmd_pkg::ST_CONTRAST: state_nxt = oled_cmd_pkg::ST_IDLE;
            oled_cmd_pkg::ST_MUX: state_nxt = oled_cmd_pkg::ST_IDLE;
            oled_cmd_pkg::ST_BOOST: state_nxt = oled_cmd_pkg::ST_IDLE;
            oled_cmd_pkg::ST_SKIP: state_nxt = oled_cmd_pkg::ST_IDLE;
            oled_cmd_pkg::ST_IDLE: begin
               case (cmdByte)
                  oled_cmd_pkg::OP_CONTRAST: state_nxt = oled_cmd_pkg::ST_CONTRAST;
                  oled_cmd_pkg::OP_MUX: state_nxt = oled_cmd_pkg::ST_MUX;
                  oled_cmd_pkg::OP_BOOST: state_nxt = oled_cmd_pkg::ST_BOOST;
                  oled_cmd_pkg::OP_OFFSET,
                  oled_cmd_pkg::OP_CLKDIV,
                  oled_cmd_pkg::OP_PRECHG,
                  oled_cmd_pkg::OP_COMPADS,
                  oled_cmd_pkg::OP_VCOMH: state_nxt = oled_cmd_pkg::ST_SKIP;
                  default: state_nxt = oled_cmd_pkg::ST_IDLE;
               endcase
            end
            default: state_nxt = oled_cmd_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_r <= oled_cmd_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Argument bytes: whatever arrives in an argument state is data, so a
   // command code sent there lands in the setting (ST_SKIP drops it), never decoded.
   // Contrast value, claimed only while contrast mode is armed.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         contrast_r <= oled_cmd_pkg::RST_CONTRAST;
      end else if (cmdWr && state_r == oled_cmd_pkg::ST_CONTRAST) begin
         contrast_r <= cmdByte;
      end
   end

   // Multiplex code and its row count. The count has its own register so
   // that the output comes straight from a flop; the top two bits are dropped.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         muxCode_r <= oled_cmd_pkg::RST_MUX;
         activeRows_r <= {1'b0, oled_cmd_pkg::RST_MUX} + 7'h01;
      end else if (cmdWr && state_r == oled_cmd_pkg::ST_MUX) begin
         muxCode_r <= cmdByte[5:0];
         activeRows_r <= {1'b0, cmdByte[5:0]} + 7'h01;
      end
   end

   // Converter enable; it only acts once the display is switched on.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         boostEn_r <= 1'b1;
      end else if (cmdWr && state_r == oled_cmd_pkg::ST_BOOST) begin
         boostEn_r <= cmdByte[0];
      end
   end

   // Single-byte commands, decoded only when no argument is awaited. Each
   // setting has its own register; codes that match none change nothing.
   assign idleCmd = cmdWr && (state_r == oled_cmd_pkg::ST_IDLE);

   // Column order toward the segment drivers.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         remap_r <= 1'b0;
      end else if (idleCmd && cmdByte[7:1] == oled_cmd_pkg::OP_REMAP[7:1]) begin
         remap_r <= cmdByte[0];
      end
   end

   // Whole-display force, which leaves the RAM alone.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         entireOn_r <= 1'b0;
      end else if (idleCmd && cmdByte[7:1] == oled_cmd_pkg::OP_ENTIRE[7:1]) begin
         entireOn_r <= cmdByte[0];
      end
   end

   // Inverse display, so that the force has something to override.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         invert_r <= 1'b0;
      end else if (idleCmd && cmdByte[7:1] == oled_cmd_pkg::OP_INVERT[7:1]) begin
         invert_r <= cmdByte[0];
      end
   end

   // Display on or off.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         dispOn_r <= 1'b0;
      end else if (idleCmd && cmdByte[7:1] == oled_cmd_pkg::OP_DISPLAY[7:1]) begin
         dispOn_r <= cmdByte[0];
      end
   end

   // Page for later RAM accesses.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         page_r <= 3'h0;
      end else if (idleCmd && cmdByte[7:3] == oled_cmd_pkg::OP_PAGE_HI) begin
         page_r <= cmdByte[2:0];
      end
   end

   // Row scan direction; the low three bits are ignored.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         scanRev_r <= 1'b0;
      end else if (idleCmd && cmdByte[7:4] == oled_cmd_pkg::OP_SCAN_HI) begin
         scanRev_r <= cmdByte[3];
      end
   end

   // Column counter: one step per RAM access, stopping at the last
   // address; the page never moves with it. Accesses run in sleep too.
   always_comb begin
      incCount = {1'b0, dataWr} + {1'b0, dataRd};
      colSum = {1'b0, column_r} + {7'h00, incCount};
      if (colSum > {1'b0, oled_cmd_pkg::COL_MAX}) begin
         column_nxt = oled_cmd_pkg::COL_MAX;
      end else begin
         column_nxt = colSum[7:0];
      end
      if (wrFire && awAddr_r == oled_cmd_pkg::OFF_COLUMN && wStrb_r[0]) begin
         // A value past the last column is held there, never beyond it.
         if (wData_r[7:0] > oled_cmd_pkg::COL_MAX) begin
            column_nxt = oled_cmd_pkg::COL_MAX;
         end else begin
            column_nxt = wData_r[7:0];
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         column_r <= 8'h00;
      end else begin
         column_r <= column_nxt;
      end
   end

   // Power and drive outputs follow the display and converter flags. Sleep
   // only gates outputs, so every setting above survives it.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sleep_r <= 1'b1;
         osc_r <= 1'b0;
         boostOn_r <= 1'b0;
         extSup_r <= 1'b0;
         drvOe_r <= 1'b0;
      end else begin
         sleep_r <= !dispOn_r;
         osc_r <= dispOn_r;
         boostOn_r <= dispOn_r && boostEn_r;
         extSup_r <= dispOn_r && !boostEn_r;
         drvOe_r <= dispOn_r;
      end
   end

   // Pixel path: forcing pixels never touches RAM; it only overrides the
   // path, and it wins over the inverse setting.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pixel_r <= 1'b0;
      end else begin
         pixel_r <= entireOn_r || (ramPixel ^ invert_r);
      end
   end

   // Scan and page settings go straight out; the row scanner picks up the
   // direction on its next row and the page only steers RAM access.
   assign scanReverse = scanRev_r;
   assign pageAddr = page_r;
   assign activeRows = activeRows_r;
   assign contrast = contrast_r;
   assign segRemap = remap_r;
   assign columnAddr = column_r;
   assign pixelOut = pixel_r;
   assign sleepMode = sleep_r;
   assign oscEnable = osc_r;
   assign boostConverterOn = boostOn_r;
   assign externalSupply = extSup_r;
   assign driverOe = drvOe_r;
   assign s_axi_awready = awReady_r;
   assign s_axi_wready = wReady_r;
   assign s_axi_bvalid = bValid_r;
   assign s_axi_bresp = bResp_r;
   assign s_axi_arready = arReady_r;
   assign s_axi_rvalid = rValid_r;
   assign s_axi_rdata = rData_r;
   assign s_axi_rresp = rResp_r;
endmodule

/* File: oled_display_command_decoder_sva.sv */
// Checker for the OLED command decoder, bound to its top module.
// Assumes it sees only top-level ports, all in the ref_clk domain.
`timescale 1ns/1ns
module oled_display_command_decoder_chk (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Bus handshakes.
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // Panel controls.
   input wire logic [7:0] contrast,
   input wire logic [6:0] activeRows,
   input wire logic [2:0] pageAddr,
   input wire logic [7:0] columnAddr,
   input wire logic sleepMode,
   input wire logic oscEnable,
   input wire logic boostConverterOn,
   input wire logic externalSupply,
   input wire logic driverOe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   // A write is taken when both channels shake hands at one edge.
   wire wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   // Settings may only move in the cycle after a write was taken.
   chk_contrast_cause: assert property (!$past(wrTake) |-> $stable(contrast))
      else $error("contrast changed without a write");
   chk_rows_cause: assert property (!$past(wrTake) |-> $stable(activeRows))
      else $error("row count changed without a write");
   chk_page_cause: assert property (!$past(wrTake) |-> $stable(pageAddr))
      else $error("page changed without a write");
   chk_rows_range: assert property (activeRows inside {[7'h01:7'h40]})
      else $error("row count out of range");
   chk_column_limit: assert property (columnAddr <= 8'h84)
      else $error("column beyond its limit");
   // Power outputs lag the display flag, so two settled cycles are demanded.
   chk_sleep_drivers: assert property (sleepMode && $past(sleepMode) |->
      !driverOe && !oscEnable && !boostConverterOn)
      else $error("drivers or oscillator active in sleep");
   chk_supply_one: assert property (!sleepMode && !$past(sleepMode) |->
      (boostConverterOn != externalSupply) && oscEnable && driverOe)
      else $error("supply selection wrong while on");
   chk_sleep_cause: assert property ($changed(sleepMode) |->
      s_axi_bvalid || $past(s_axi_bvalid))
      else $error("sleep changed outside a write");
   chk_write_answer: assert property (wrTake |=> s_axi_bvalid)
      else $error("write response missing");
   chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response missing");
   cover property (wrTake);
   cover property (!sleepMode && boostConverterOn);
   cover property (!sleepMode && externalSupply);
   cover property (columnAddr == 8'h84);
endmodule
bind oled_display_command_decoder oled_display_command_decoder_chk i_chk (.ref_clk, .rst,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .contrast, .activeRows,
   .pageAddr, .columnAddr, .sleepMode, .oscEnable, .boostConverterOn, .externalSupply,
   .driverOe);

/* File: oled_host_model.sv */
// Host processor model: an AXI4-Lite master writing command bytes.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ns
module oled_host_model (
   // Clock.
   input wire logic ref_clk,
   // Write channels.
   output logic [4:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic [3:0] wstrb,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   // Read channels.
   output logic [4:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   // Response ready stays high, which also avoids rewriting it between transfers.
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, araddr, arvalid} = '0;
      bready = 1'b1;
      rready = 1'b1;
   end
   // Released payload is inverted so a stale value cannot pass for a live one.
   task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
      logic awDone;
      logic wDone;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awDone = 1'b0;
      wDone = 1'b0;
      // Each channel is released at the edge that takes it, in either order.
      while (!(awDone && wDone)) begin
         @(posedge ref_clk);
         if (!awDone && awready) begin
            awDone = 1'b1;
            awvalid <= 1'b0;
            awaddr <= ~a;
         end
         if (!wDone && wready) begin
            wDone = 1'b1;
            wvalid <= 1'b0;
            wdata <= ~d;
         end
      end
      do @(posedge ref_clk); while (!bvalid);
      r = bresp;
   endtask
   // One read, held until the address is taken.
   task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge ref_clk); while (!arready);
      arvalid <= 1'b0;
      araddr <= ~a;
      do @(posedge ref_clk); while (!rvalid);
      d = rdata;
      r = rresp;
   endtask
endmodule

/* File: oled_display_command_decoder_tb.sv */
// Self-checking bench for the OLED command decoder against a model.
// Assumes the host model as bus master and the checker bound in.
`timescale 1ns/1ns
module oled_display_command_decoder_tb;
   logic ref_clk, rst, ramPixel, pixelOut, segRemap, scanReverse, sleepMode, oscEnable;
   logic boostConverterOn, externalSupply, driverOe, s_axi_awvalid, s_axi_awready;
   logic s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [4:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [7:0] contrast, columnAddr;
   logic [6:0] activeRows;
   logic [2:0] pageAddr;
   int bad_count, tests_run, seed, shade, muxCode, pageSel, remapOn, wholeOn, dispOn;
   int boostOn, scanRev, invOn, armState, colCount;
   int cmds[] = '{8'h81, 8'h3C, 8'h81, 8'hA5, 8'hA1, 8'hA0, 8'hA5, 8'hA7, 8'hA4, 8'hA6,
      8'hA8, 8'hFF, 8'hA8, 8'h00, 8'hAD, 8'h8A, 8'hAF, 8'hAE, 8'hAD, 8'h8B, 8'hAF, 8'hB5,
      8'hB7, 8'hC8, 8'hC7, 8'hD3, 8'h81, 8'hE3, 8'hAE};
   oled_display_command_decoder i_dut (.*);
   oled_host_model i_host (.ref_clk(ref_clk), .awaddr(s_axi_awaddr), .awvalid(s_axi_awvalid),
      .awready(s_axi_awready), .wdata(s_axi_wdata), .wstrb(s_axi_wstrb), .wvalid(s_axi_wvalid),
      .wready(s_axi_wready), .bresp(s_axi_bresp), .bvalid(s_axi_bvalid), .bready(s_axi_bready),
      .araddr(s_axi_araddr), .arvalid(s_axi_arvalid), .arready(s_axi_arready),
      .rdata(s_axi_rdata), .rresp(s_axi_rresp), .rvalid(s_axi_rvalid), .rready(s_axi_rready));
   // Clock at 100 ns and a random pixel stream from display RAM.
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) ramPixel <= 1'($random(seed));
   // Counts every comparison and reports mismatches at once.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Compares readback and every panel output with the model.
   task automatic verify;
      int e;
      int p;
      e = shade | muxCode << oled_cmd_pkg::CFG_MUX_LSB | pageSel << oled_cmd_pkg::CFG_PAGE_LSB
         | remapOn << oled_cmd_pkg::CFG_REMAP_BIT | wholeOn << oled_cmd_pkg::CFG_ENTIRE_BIT
         | dispOn << oled_cmd_pkg::CFG_DISP_BIT | boostOn << oled_cmd_pkg::CFG_BOOST_BIT
         | scanRev << oled_cmd_pkg::CFG_SCAN_BIT | invOn << oled_cmd_pkg::CFG_INVERT_BIT
         | armState << oled_cmd_pkg::CFG_STATE_LSB;
      i_host.rd(oled_cmd_pkg::OFF_CONFIG, rv, rs);
      chk(rv, e);
      chk(contrast, shade);
      chk(activeRows, muxCode + 1);
      chk(segRemap, remapOn);
      chk(scanReverse, scanRev);
      chk(pageAddr, pageSel);
      chk(columnAddr, colCount);
      chk(sleepMode, !dispOn);
      chk({oscEnable, driverOe}, {2{dispOn[0]}});
      chk({boostConverterOn, externalSupply}, {dispOn[0] & boostOn[0], dispOn[0] & ~boostOn[0]});
      @(negedge ref_clk) p = ramPixel;
      @(negedge ref_clk) chk(pixelOut, wholeOn | (p ^ invOn));
      @(posedge ref_clk);
   endtask
   // Sends one byte and advances the model the way the decoder should.
   task automatic send(input int b, input int sel);
      i_host.wr(oled_cmd_pkg::OFF_CMD, b | sel << oled_cmd_pkg::CMD_SEL_BIT, rs);
      chk(rs, oled_cmd_pkg::RESP_OKAY);
      if (sel != 0) colCount += (colCount < 8'h84);
      else if (armState == 1) shade = b;
      else if (armState == 2) muxCode = b & 8'h3F;
      else if (armState == 3) boostOn = b & 1;
      else if (armState == 0) begin
         if (b == 8'h81) armState = 1;
         else if (b == 8'hA8) armState = 2;
         else if (b == 8'hAD) armState = 3;
         else if (b inside {8'hD3, 8'hD5, 8'hD9, 8'hDA, 8'hDB}) armState = 4;
         else if (b >> 1 == 8'h50) remapOn = b & 1;
         else if (b >> 1 == 8'h52) wholeOn = b & 1;
         else if (b >> 1 == 8'h53) invOn = b & 1;
         else if (b >> 1 == 8'h57) dispOn = b & 1;
         else if (b >> 3 == 8'h16) pageSel = b & 8'h07;
         else if (b >> 4 == 8'h0C) scanRev = b >> 3 & 1;
         armState = (armState == 0) ? 0 : armState + 8;
      end
      if (sel == 0) armState = (armState > 8) ? armState - 8 : 0;
      verify;
   endtask
   // Main sequence.
   initial begin
      int b;
      seed = 32'h145E;
      rst = 1'b1;
      shade = 8'h80;
      muxCode = 8'h3F;
      boostOn = 1;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      verify;
      foreach (cmds[i]) send(cmds[i], 0);
      // Random commands; display toggles are kept out, display stays off.
      repeat (40) begin
         b = 8'h80 | 8'($random(seed));
         if (armState == 0 && b >> 1 == 8'h57) b = 8'hE3;
         send(b, 0);
      end
      send(8'hE3, 0);
      i_host.wr(oled_cmd_pkg::OFF_COLUMN, 32'h82, rs);
      colCount = 8'h82;
      repeat (3) send(8'h00, 1);
      i_host.rd(oled_cmd_pkg::OFF_DATA, rv, rs);
      chk(rv, 32'h0);
      i_host.wr(oled_cmd_pkg::OFF_COLUMN, 32'hFF, rs);
      chk(columnAddr, 8'h84);
      i_host.wr(oled_cmd_pkg::OFF_COLUMN, 32'h0, rs);
      i_host.rd(oled_cmd_pkg::OFF_DATA, rv, rs);
      colCount = 1;
      i_host.rd(oled_cmd_pkg::OFF_COLUMN, rv, rs);
      chk(rv, colCount);
      i_host.wr(5'h10, 32'hFF, rs);
      chk(rs, oled_cmd_pkg::RESP_SLVERR);
      i_host.wr(oled_cmd_pkg::OFF_CONFIG, 32'hFF, rs);
      chk(rs, oled_cmd_pkg::RESP_SLVERR);
      i_host.rd(5'h14, rv, rs);
      chk(rv, 32'h0);
      chk(rs, oled_cmd_pkg::RESP_SLVERR);
      verify;
      wrap_up;
   end
   // Cuts a hang short after far more time than the sequence needs.
   initial begin
      #3000000;
      bad_count++;
      wrap_up;
   end
   task automatic wrap_up;
      if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
endmodule
